/* pkg/csb_pkg.sv */
// constants shared by the cell balance supervisor
package csb_pkg;
  // register byte offsets
  localparam logic [7:0] CSB_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSB_OFF_SWEN = 8'h04;
  localparam logic [7:0] CSB_OFF_CHEN = 8'h08;
  localparam logic [7:0] CSB_OFF_BIPOLAR = 8'h0c;
  localparam logic [7:0] CSB_OFF_THR = 8'h10;
  localparam logic [7:0] CSB_OFF_STAT = 8'h14;
  localparam logic [7:0] CSB_OFF_ELAPSED = 8'h18;
  localparam logic [7:0] CSB_OFF_EXPIRY = 8'h1c;
  localparam logic [7:0] CSB_OFF_SCAN = 8'h20;
  localparam logic [7:0] CSB_OFF_ALERT = 8'h24;
  // control, threshold and alert register field positions
  localparam int CSB_CTL_MODE_LSB = 0;
  localparam int CSB_CTL_MEAS_LSB = 4;
  localparam int CSB_CTL_DUTY_LSB = 8;
  localparam int CSB_CTL_NTFY_LSB = 12;
  localparam int CSB_CTL_SEED_BIT = 14;
  localparam int CSB_CTL_CALEN_BIT = 15;
  localparam int CSB_CTL_CALDLY_LSB = 16;
  localparam int CSB_CTL_MINSEL_BIT = 19;
  localparam int CSB_CTL_HOLD_BIT = 20;
  localparam int CSB_THR_MINSEL_BIT = 15;
  localparam int CSB_ALR_NTFY_BIT = 0;
  localparam int CSB_ALR_RJCT_BIT = 1;
  // balance modes
  localparam logic [2:0] CSB_MODE_OFF = 3'h0;
  localparam logic [2:0] CSB_MODE_DISCH = 3'h1;
  // embedded measurement select codes
  localparam logic [1:0] CSB_MEAS_FLOOR = 2'h3;
  // filter coefficient codes
  localparam logic [2:0] CSB_IIR_BYPASS = 3'h7;
  localparam logic [2:0] CSB_IIR_DEBOUNCE = 3'h0;
  // forced scan settings during balancing
  localparam logic [2:0] CSB_OVS_16X = 3'h4;
  localparam logic [1:0] CSB_SCAN_PYRAMID = 2'h1;
  // coefficient sources
  localparam logic [1:0] CSB_COEF_FACTORY = 2'h0;
  localparam logic [1:0] CSB_COEF_PRE = 2'h1;
  localparam logic [1:0] CSB_COEF_PERIODIC = 2'h2;
  // timing: one slot is a sixteenth of the 30 s period
  localparam longint CSB_CLK_KHZ = 200000;
  localparam longint CSB_SLOT_TIME_MS = 1875;
  localparam int CSB_SLOT_CYCLES = int'(CSB_CLK_KHZ * CSB_SLOT_TIME_MS);
  localparam longint CSB_GAP_TIME_NS = 1000;
  localparam int CSB_GAP_CYCLES = int'((CSB_GAP_TIME_NS * CSB_CLK_KHZ + 999999) / 1000000);
  localparam logic [3:0] CSB_SLOTS_LAST = 4'hf;
  localparam logic [15:0] CSB_SLOTS_PER_HOUR = 16'd1920;
  localparam logic [4:0] CSB_SEED_SETTLE = 5'd16;
  localparam logic [5:0] CSB_WALL_CYCLE_SLOTS = 6'd32;
endpackage

/* testbench/csb_supervisor_properties.sv */
// port assertions for the cell balance supervisor
`timescale 1ns/1ps
module csb_supervisor_properties
  import csb_pkg::*;
#(
  parameter int NCELL = 14
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic [NCELL-1:0] o_switch_on,
  input wire logic o_meas_req,
  input wire logic o_cal_req,
  input wire logic [2:0] o_oversample,
  input wire logic [1:0] o_scan_order,
  input wire logic o_active
);
  // ---------------------------------
  // switch groups and bus answer shape
  // ---------------------------------
  localparam logic [NCELL-1:0] ODD_M = NCELL'({8{2'b10}});
  localparam logic [NCELL-1:0] EVEN_M = ~ODD_M;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  sequence s_even_off;
    (o_switch_on & EVEN_M) == '0;
  endsequence
  chk_bus_answer: assert property ((i_read || i_write) && o_waitrequest |=> s_answer)
    else $error("bus answer not one cycle");
  chk_bus_idle: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
    else $error("bus answered without request");
  chk_forced_ovs: assert property (o_active && $past(o_active) |-> o_oversample == CSB_OVS_16X)
    else $error("oversample not forced");
  chk_forced_order: assert property (o_active && $past(o_active) |-> o_scan_order == 2'h1)
    else $error("scan order not forced");
  chk_meas_pulse: assert property (o_meas_req |=> !o_meas_req)
    else $error("measure request too long");
  chk_cal_pulse: assert property (o_cal_req |=> !o_cal_req)
    else $error("calibration request too long");
  chk_req_excl: assert property (!(o_meas_req && o_cal_req))
    else $error("measure and calibration together");
  chk_no_overlap: assert property ((o_switch_on & ODD_M) != '0 |-> s_even_off)
    else $error("adjacent switches on together");
  chk_gap_after: assert property (($past(o_switch_on) & ODD_M) != '0 && (o_switch_on & ODD_M) == '0
    |-> s_even_off [*2])
    else $error("no gap after odd group");
  chk_idle_off: assert property (!o_active && !$past(o_active) |-> o_switch_on == '0)
    else $error("switch on while idle");
endmodule // csb_supervisor_properties

bind csb_supervisor csb_supervisor_properties #(.NCELL(NCELL)) i_csb_supervisor_properties (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_read(i_read),
  .i_write(i_write),
  .o_waitrequest(o_waitrequest),
  .o_switch_on(o_switch_on),
  .o_meas_req(o_meas_req),
  .o_cal_req(o_cal_req),
  .o_oversample(o_oversample),
  .o_scan_order(o_scan_order),
  .o_active(o_active)
);

/* testbench/tb_top.sv */
// self-checking bench for the cell balance supervisor
`timescale 1ns/1ps
module tb_top;
  import csb_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} csb_row_t;
  localparam int SLOT = 20;
  logic i_clk, i_resetn, i_read, i_write, i_result_valid, i_seq_done;
  logic o_waitrequest, o_meas_req, o_cal_req, o_active;
  logic [7:0] i_address;
  logic [31:0] i_writedata, o_readdata, rd;
  logic [3:0] i_lowest_index, i_result_cell;
  logic [13:0] i_result_value, o_switch_on, seen;
  logic [2:0] o_oversample;
  logic [1:0] o_scan_order, o_coef_source;
  int errors, checks, n, ons;
  logic cal;
  csb_row_t rows [5] = '{'{CSB_OFF_THR, 32'hffff_ffff, 32'h0000_3fff},
    '{CSB_OFF_THR, 32'h0000_2abc, 32'h0000_2abc}, '{CSB_OFF_SCAN, 32'h0000_001d, 32'h0000_001d},
    '{CSB_OFF_STAT, 32'h0000_3fff, 32'h0}, '{8'h40, 32'hffff_ffff, 32'h0}};

  csb_supervisor #(.NCELL(14), .SLOT_CYCLES(SLOT), .GAP_CYCLES(2)) i_csb_supervisor (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_lowest_index(i_lowest_index),
    .i_result_valid(i_result_valid), .i_result_cell(i_result_cell),
    .i_result_value(i_result_value), .i_seq_done(i_seq_done), .o_switch_on(o_switch_on),
    .o_meas_req(o_meas_req), .o_cal_req(o_cal_req), .o_oversample(o_oversample),
    .o_scan_order(o_scan_order), .o_coef_source(o_coef_source), .o_active(o_active)
  );

  // ---------------------------------
  // clock and helper tasks
  // ---------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic close_out;
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) fail($sformatf("got %h want %h", g, e));
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] w);
    @(posedge i_clk);
    i_write <= we;
    i_read <= !we;
    i_address <= a;
    i_writedata <= w;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (o_waitrequest === 1'b0) break;
    end
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    if (n == 50) begin
      fail("bus timeout");
      close_out();
    end
  endtask

  // one-cycle result or sequence-done pulse
  task automatic pulse(input logic [3:0] c, input logic [13:0] v, input logic done);
    @(posedge i_clk);
    i_result_valid <= !done;
    i_seq_done <= done;
    i_result_cell <= c;
    i_result_value <= v;
    @(posedge i_clk);
    i_result_valid <= 1'b0;
    i_seq_done <= 1'b0;
  endtask

  // waits for a measure or calibration request, counting switch activity meanwhile
  task automatic wait_req;
    ons = 0;
    seen = '0;
    for (n = 0; n < 3000; n++) begin
      @(posedge i_clk);
      cal = o_cal_req;
      if (o_meas_req === 1'b1 || cal === 1'b1) break;
      seen = seen | o_switch_on;
      if (|o_switch_on) ons++;
    end
    if (n == 3000) begin
      fail("no measure request");
      close_out();
    end
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] s,
                                      input logic [3:0] d);
    ctl = 32'h0;
    ctl[CSB_CTL_MODE_LSB +: 3] = m;
    ctl[CSB_CTL_MEAS_LSB +: 2] = s;
    ctl[CSB_CTL_DUTY_LSB +: 4] = d;
  endfunction

  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    errors = 0;
    checks = 0;
    {i_resetn, i_read, i_write, i_result_valid, i_seq_done} = 5'h0;
    {i_address, i_writedata, i_lowest_index, i_result_cell, i_result_value} = '0;
    repeat (3) @(posedge i_clk);
    cmp({o_waitrequest, o_active, o_switch_on}, 32'h0000_8000);
    i_resetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      cmp(rd, rows[i].e);
    end
    cmp({o_scan_order, o_oversample}, 32'h1d);
    // threshold taken from the lowest-reading cell
    i_lowest_index <= 4'h3;
    bus(1'b1, CSB_OFF_EXPIRY, 32'd200);
    bus(1'b1, CSB_OFF_CTRL, ctl(CSB_MODE_DISCH, 2'b00, 4'h0) | 32'h0008_4000);
    pulse(4'h3, 14'h0abc, 1'b0);
    bus(1'b1, CSB_OFF_THR, 32'h0000_1111);
    bus(1'b0, CSB_OFF_THR, 32'h0);
    cmp(rd, 32'h0000_8abc);
    bus(1'b1, CSB_OFF_CTRL, 32'h0);
    // discharge at duty code 1, scan write refused
    bus(1'b1, CSB_OFF_SWEN, 32'h3fff);
    bus(1'b1, CSB_OFF_CHEN, 32'h3fff);
    bus(1'b1, CSB_OFF_CTRL, ctl(CSB_MODE_DISCH, 2'b10, 4'h1) | 32'h0001_8000);
    repeat (3) @(posedge i_clk);
    cmp({o_active, o_oversample, o_scan_order}, {1'b1, CSB_OVS_16X, 2'h1});
    cmp(o_coef_source, CSB_COEF_PERIODIC);
    bus(1'b1, CSB_OFF_SCAN, 32'h2);
    bus(1'b0, CSB_OFF_SCAN, 32'h0);
    cmp(rd, 32'h1d);
    bus(1'b0, CSB_OFF_ALERT, 32'h0);
    cmp(rd[CSB_ALR_RJCT_BIT], 1'b1);
    wait_req;
    cmp(cal, 1'b1);
    pulse(4'h0, 14'h0, 1'b1);
    wait_req;
    cmp(cal, 1'b0);
    cmp(ons, 4 * SLOT);
    pulse(4'h0, 14'h0, 1'b1);
    repeat (5) @(posedge i_clk);
    bus(1'b0, CSB_OFF_ELAPSED, 32'h0);
    cmp(rd, 32'd4);
    bus(1'b1, CSB_OFF_CTRL, 32'h0);
    // auto group balancing to the floor
    bus(1'b1, CSB_OFF_SWEN, 32'h7);
    bus(1'b1, CSB_OFF_CHEN, 32'h3);
    bus(1'b1, CSB_OFF_THR, 32'h100);
    bus(1'b1, CSB_OFF_CTRL, ctl(3'h6, CSB_MEAS_FLOOR, 4'h0) | 32'h0000_8000);
    wait_req;
    cmp(o_coef_source, CSB_COEF_PRE);
    pulse(4'h0, 14'h0, 1'b0);
    pulse(4'h1, 14'h3fff, 1'b0);
    pulse(4'h0, 14'h0, 1'b1);
    wait_req;
    cmp(seen, 14'h0002);
    bus(1'b0, CSB_OFF_STAT, 32'h0);
    cmp(rd, 32'h5);
    bus(1'b1, CSB_OFF_CTRL, 32'h0);
    bus(1'b0, CSB_OFF_STAT, 32'h0);
    cmp(rd, 32'h0);
    cmp(o_coef_source, CSB_COEF_FACTORY);
    close_out();
  end
endmodule // tb_top

/* verilog/csb_supervisor.sv */
// cell balance supervisor with avalon-mm register slave
`timescale 1ns/1ps
// Summary of operation
// - in discharge mode the elapsed counter grows by the active duty share only.
// - duty code sets on-time per 30 s; 0x0 is 1.875 s, 0xF full less gap.
// - duty code 1 adds 3.750 s to elapsed count per even/odd/measure cycle.
// - progress alert every 1, 2, 4 or 8 wall-clock hours in automatic and discharge modes.
// - progress alerts continue during the shutdown-hold extension after completion.
// - a cell reaching the floor turns its switch off until balancing restarts.
// - floor checks need switch and channel enabled, unipolar; a switch-enabled cell lacking these ends flagged.
// - floor flag n marks cell n ended; cleared only by a mode write.
// - measure select 0b11 balances to the floor in auto modes; expiry timer stays a backstop.
// - once all enabled cells hit the floor, switches off, elapsed counter runs on.
// - floor threshold is 14 bits at 305 uV per count.
// - threshold write loads data, or the lowest-reading cell result when selected.
// - threshold read returns threshold in force and the lowest-reading flag.
// - select 0b0x no measurements, 0b1x measure, 0b11 also floor checks in auto.
// - measure select acts only in discharge and automated modes.
// - balancing forces 16x pyramid scans; scan writes rejected with an alert.
// - each measurement is filtered; bypass coefficient becomes 1/8 while balancing.
// - seeding clear keeps the filter accumulators on entry.
// - seeding set loads filters from first measurement, checks begin at the 17th.
// - nonzero calibration interleave replaces measurements with calibrations periodically.
// - coefficient source follows apply-calibration and interleave setting.
// - a gap separates turning one switch group off and the other on.
module csb_supervisor
  import csb_pkg::*;
#(
  parameter int NCELL = 14,
  parameter int SLOT_CYCLES = CSB_SLOT_CYCLES,
  parameter int GAP_CYCLES = CSB_GAP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [3:0] i_lowest_index,
  input wire logic i_result_valid,
  input wire logic [3:0] i_result_cell,
  input wire logic [13:0] i_result_value,
  input wire logic i_seq_done,
  output logic [NCELL-1:0] o_switch_on,
  output logic o_meas_req,
  output logic o_cal_req,
  output logic [2:0] o_oversample,
  output logic [1:0] o_scan_order,
  output logic [1:0] o_coef_source,
  output logic o_active
);
  typedef enum {ST_IDLE, ST_RUN, ST_GAP, ST_MEAS, ST_DONE} csb_state_t;
  typedef struct packed {
    csb_state_t st;
    logic [31:0] ctrl;
    logic [NCELL-1:0] swen;
    logic [NCELL-1:0] chen;
    logic [NCELL-1:0] bipolar;
    logic [13:0] thr;
    logic [NCELL-1:0] floor_flags;
    logic [19:0] elapsed;
    logic [19:0] expiry;
    logic [4:0] scan;
    logic ntfy_alert;
    logic rjct_alert;
    logic [NCELL-1:0][13:0] acc;
    logic [NCELL-1:0] seeded;
    logic [4:0] seq_cnt;
    logic [31:0] cyc;
    logic [3:0] slot;
    logic odd;
    logic [31:0] wall_cyc;
    logic [15:0] wall_slots;
    logic [5:0] cal_cnt;
    logic [NCELL-1:0] sw;
    logic meas_req;
    logic cal_req;
    logic [31:0] rdata;
    logic waitreq;
    logic [2:0] ovs;
    logic [1:0] order;
    logic [1:0] coef;
    logic active;
  } csb_reg_t;

  csb_reg_t r_q;
  csb_reg_t r_d;

  // calibration spacing in measurement cycles per interleave code
  function automatic logic [5:0] cal_period(input logic [2:0] sel);
    unique case (sel)
      3'h1: cal_period = 6'd2;
      3'h2: cal_period = 6'd4;
      3'h3: cal_period = 6'd8;
      3'h4: cal_period = 6'd12;
      3'h5: cal_period = 6'd16;
      3'h6: cal_period = 6'd24;
      3'h7: cal_period = 6'd32;
      default: cal_period = 6'd0;
    endcase
  endfunction

  // one iir step: y += (x - y) * (k + 1) / 8
  function automatic logic [13:0] iir_step(input logic [13:0] y, input logic [13:0] x,
                                           input logic [2:0] k);
    logic signed [15:0] diff;
    logic signed [20:0] prod;
    logic signed [20:0] sum;
    diff = signed'({2'h0, x}) - signed'({2'h0, y});
    prod = diff * signed'({2'h0, k} + 5'sd1);
    sum = signed'({7'h0, y}) + (prod >>> 3);
    iir_step = sum[13:0];
  endfunction

  logic [2:0] mode;
  logic [1:0] msel;
  logic [3:0] duty;
  logic [1:0] ntfy_sel;
  logic [2:0] caldly;
  logic disch;
  logic automode;
  logic running;
  logic [NCELL-1:0] even_mask;
  logic [NCELL-1:0] floor_ok;

  // --------------------------------------------------------------
  // control field decode
  // --------------------------------------------------------------
  assign mode = r_q.ctrl[CSB_CTL_MODE_LSB +: 3];
  assign msel = r_q.ctrl[CSB_CTL_MEAS_LSB +: 2];
  assign duty = r_q.ctrl[CSB_CTL_DUTY_LSB +: 4];
  assign ntfy_sel = r_q.ctrl[CSB_CTL_NTFY_LSB +: 2];
  assign caldly = r_q.ctrl[CSB_CTL_CALDLY_LSB +: 3];
  assign disch = (mode == CSB_MODE_DISCH);
  assign automode = mode[2];
  assign running = (r_q.st == ST_RUN) || (r_q.st == ST_GAP) || (r_q.st == ST_MEAS);
  // cells that may be floor checked
  // supported cells
  assign floor_ok = r_q.swen & r_q.chen & ~r_q.bipolar;

  genvar gi;
  generate
    for (gi = 0; gi < NCELL; gi++) begin : g_even
      assign even_mask[gi] = ((gi % 2) == 0);
    end
  endgenerate

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic req;
    logic wr;
    logic launch;
    logic slot_end;
    logic duty_on;
    logic [2:0] k;
    logic [4:0] seq_next;
    logic [13:0] filt;
    logic wall_hit;
    req = 1'b0;
    wr = 1'b0;
    launch = 1'b0;
    slot_end = 1'b0;
    duty_on = 1'b0;
    k = 3'h0;
    seq_next = 5'h0;
    filt = 14'h0;
    wall_hit = 1'b0;
    r_d = r_q;
    r_d.meas_req = 1'b0;
    r_d.cal_req = 1'b0;

    // avalon slave: one wait cycle, then answer
    req = i_read | i_write;
    r_d.waitreq = ~(req & r_q.waitreq);
    wr = i_write & ~r_q.waitreq;
    if (req & r_q.waitreq) begin
      unique case (i_address)
        CSB_OFF_CTRL: r_d.rdata = r_q.ctrl;
        CSB_OFF_SWEN: r_d.rdata = 32'(r_q.swen);
        CSB_OFF_CHEN: r_d.rdata = 32'(r_q.chen);
        CSB_OFF_BIPOLAR: r_d.rdata = 32'(r_q.bipolar);
        CSB_OFF_THR: r_d.rdata = 32'({r_q.ctrl[CSB_CTL_MINSEL_BIT], 1'b0, r_q.thr});
        CSB_OFF_STAT: r_d.rdata = 32'(r_q.floor_flags);
        CSB_OFF_ELAPSED: r_d.rdata = 32'(r_q.elapsed);
        CSB_OFF_EXPIRY: r_d.rdata = 32'(r_q.expiry);
        CSB_OFF_SCAN: r_d.rdata = 32'(r_q.scan);
        CSB_OFF_ALERT: r_d.rdata = 32'({r_q.rjct_alert, r_q.ntfy_alert});
        default: r_d.rdata = 32'h0;
      endcase
    end

    // register writes
    if (wr) begin
      unique case (i_address)
        CSB_OFF_CTRL: begin
          r_d.ctrl = i_writedata & 32'h001f_ff37;
          launch = 1'b1;
        end
        CSB_OFF_SWEN: r_d.swen = i_writedata[NCELL-1:0];
        CSB_OFF_CHEN: r_d.chen = i_writedata[NCELL-1:0];
        CSB_OFF_BIPOLAR: r_d.bipolar = i_writedata[NCELL-1:0];
        CSB_OFF_THR: r_d.thr = r_q.ctrl[CSB_CTL_MINSEL_BIT] ?
                               r_q.acc[i_lowest_index] : i_writedata[13:0];
        CSB_OFF_EXPIRY: r_d.expiry = i_writedata[19:0];
        CSB_OFF_SCAN: begin
          if (running) begin
            r_d.rjct_alert = 1'b1;
          end else begin
            r_d.scan = i_writedata[4:0];
          end
        end
        CSB_OFF_ALERT: begin
          if (i_writedata[CSB_ALR_NTFY_BIT]) begin
            r_d.ntfy_alert = 1'b0;
          end
          if (i_writedata[CSB_ALR_RJCT_BIT] & ~running) begin
            r_d.rjct_alert = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // balancing sequencer
    slot_end = (r_q.cyc == 32'(SLOT_CYCLES - 1));
    unique case (r_q.st)
      ST_IDLE: ;
      ST_GAP: begin
        r_d.sw = '0;
        // gap before the other group turns on
        if (r_q.cyc == 32'(GAP_CYCLES - 1)) begin
          r_d.cyc = 32'h0;
          r_d.st = ST_RUN;
        end else begin
          r_d.cyc = r_q.cyc + 32'h1;
        end
      end
      ST_RUN: begin
        // on for the first duty+1 slots; sixteenths
        duty_on = disch ? (r_q.slot <= duty) : 1'b1;
        // floored cells stay off; all off once all floored
        r_d.sw = (r_q.odd ? ~even_mask : even_mask) & r_q.swen & ~r_q.floor_flags
                 & {NCELL{duty_on}};
        r_d.cyc = slot_end ? 32'h0 : r_q.cyc + 32'h1;
        if (slot_end) begin
          r_d.slot = r_q.slot + 4'h1;
        end
        if (slot_end && (r_q.slot == CSB_SLOTS_LAST)) begin
          r_d.sw = '0;
          r_d.odd = ~r_q.odd;
          if (!r_q.odd) begin
            r_d.st = ST_GAP;
          end else begin
            // discharge mode counts duty share; duty 1 adds two slots
            r_d.elapsed = r_q.elapsed + (disch ? 20'(duty) + 20'h1 :
                                                 20'(CSB_WALL_CYCLE_SLOTS));
            // measurements only when select is 0b1x; these modes only
            if (msel[1] && (disch || automode)) begin
              r_d.st = ST_MEAS;
              if ((caldly != 3'h0) && (r_q.cal_cnt == 6'h0)) begin
                r_d.cal_req = 1'b1;
              end else begin
                r_d.meas_req = 1'b1;
              end
              if (caldly != 3'h0) begin
                r_d.cal_cnt = (r_q.cal_cnt == cal_period(caldly) - 6'h1) ?
                              6'h0 : r_q.cal_cnt + 6'h1;
              end
            end else begin
              r_d.st = ST_GAP;
            end
            // expiry stays a backstop to the floor
            if (r_d.elapsed >= r_q.expiry) begin
              r_d.st = ST_DONE;
            end
          end
        end
      end
      ST_MEAS: begin
        r_d.sw = '0;
        r_d.cyc = 32'h0;
        if (i_seq_done) begin
          r_d.st = ST_GAP;
          seq_next = (r_q.seq_cnt == CSB_SEED_SETTLE) ? r_q.seq_cnt : r_q.seq_cnt + 5'h1;
          r_d.seq_cnt = seq_next;
        end
      end
      ST_DONE: r_d.sw = '0;
      default: r_d.st = ST_IDLE;
    endcase

    // per-cell filter, bypass becomes 1/8 debounce
    k = (r_q.ctrl[CSB_CTL_DUTY_LSB+4 +: 3] == CSB_IIR_BYPASS) ? CSB_IIR_DEBOUNCE :
        r_q.ctrl[CSB_CTL_DUTY_LSB+4 +: 3];
    if (i_result_valid && running && (32'(i_result_cell) < NCELL)) begin
      filt = iir_step(r_q.acc[i_result_cell], i_result_value, k);
      if (r_q.ctrl[CSB_CTL_SEED_BIT] && !r_q.seeded[i_result_cell]) begin
        filt = i_result_value;
      end
      r_d.acc[i_result_cell] = filt;
      r_d.seeded[i_result_cell] = 1'b1;
      // compare 14-bit counts; auto modes with select 0b11 only
      // with seeding set, checks start at the 17th measurement
      if (automode && (msel == CSB_MEAS_FLOOR) && floor_ok[i_result_cell] &&
          (!r_q.ctrl[CSB_CTL_SEED_BIT] || (r_q.seq_cnt == CSB_SEED_SETTLE)) &&
          (filt <= r_q.thr)) begin
        r_d.floor_flags[i_result_cell] = 1'b1;
        r_d.sw[i_result_cell] = 1'b0;
      end
    end

    // wall-clock progress alert; also during the hold extension
    if ((running || (r_q.st == ST_DONE && r_q.ctrl[CSB_CTL_HOLD_BIT])) &&
        (disch || automode)) begin
      if (r_q.wall_cyc == 32'(SLOT_CYCLES - 1)) begin
        r_d.wall_cyc = 32'h0;
        wall_hit = (r_q.wall_slots == (CSB_SLOTS_PER_HOUR << ntfy_sel) - 16'h1);
        r_d.wall_slots = wall_hit ? 16'h0 : r_q.wall_slots + 16'h1;
        if (wall_hit) begin
          r_d.ntfy_alert = 1'b1;
        end
      end else begin
        r_d.wall_cyc = r_q.wall_cyc + 32'h1;
      end
    end

    // a mode write starts or aborts an operation
    if (launch) begin
      r_d.floor_flags = '0;
      r_d.elapsed = 20'h0;
      r_d.cyc = 32'h0;
      r_d.slot = 4'h0;
      r_d.odd = 1'b0;
      r_d.wall_cyc = 32'h0;
      r_d.wall_slots = 16'h0;
      r_d.cal_cnt = 6'h0;
      r_d.seq_cnt = 5'h0;
      r_d.sw = '0;
      r_d.seeded = '0;
      r_d.st = ST_IDLE;
      if (i_writedata[CSB_CTL_MODE_LSB +: 3] != CSB_MODE_OFF) begin
        r_d.st = (r_q.expiry == 20'h0) ? ST_DONE : ST_RUN;
        // switch-enabled unsupported cells end at once flagged when floor checking
        if (i_writedata[CSB_CTL_MODE_LSB+2] &&
            (i_writedata[CSB_CTL_MEAS_LSB +: 2] == CSB_MEAS_FLOOR)) begin
          r_d.floor_flags = r_q.swen & ~floor_ok;
        end
      end
    end
    // forced scan settings while balancing; coefficient source
    r_d.active = (r_d.st != ST_IDLE) && (r_d.st != ST_DONE);
    r_d.ovs = r_d.active ? CSB_OVS_16X : r_d.scan[2:0];
    r_d.order = r_d.active ? CSB_SCAN_PYRAMID : r_d.scan[4:3];
    r_d.coef = !r_d.ctrl[CSB_CTL_CALEN_BIT] ? CSB_COEF_FACTORY :
               (r_d.ctrl[CSB_CTL_CALDLY_LSB +: 3] != 3'h0) ? CSB_COEF_PERIODIC : CSB_COEF_PRE;
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.waitreq <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_readdata = r_q.rdata;
  assign o_waitrequest = r_q.waitreq;
  assign o_switch_on = r_q.sw;
  assign o_meas_req = r_q.meas_req;
  assign o_cal_req = r_q.cal_req;
  assign o_oversample = r_q.ovs;
  assign o_scan_order = r_q.order;
  assign o_coef_source = r_q.coef;
  assign o_active = r_q.active;
endmodule // csb_supervisor
